// ### logic/fdp_pkg.sv
// Constants and types shared by the floppy controller core.
// What this block does
// RULE_01: Step-rate code sets step interval, 8 ms (code 0) to 0.5 ms at 1 Mbps.
// RULE_02: Head-load code gives that many ms at 1 Mbps; code 00 gives 128 ms.
// RULE_03: Perpendicular command sets four drives via select bits or gap/write-gate bits.
// RULE_04: Nonzero gap/write-gate pair decides behaviour; per-drive select bits are ignored.
// RULE_05: With pair zero, a set per-drive bit makes that drive perpendicular.
// RULE_06: Software reset keeps per-drive bits and clears gap and write-gate bits.
// RULE_07: Pair 00 22/0, 01 22/19, 10 conventional, 11 41/38 gap bytes.
// RULE_08: Per-drive perpendicular gets 22/19 below 1 Mbps, 41/38 at 1 Mbps.
// RULE_09: Format and write commands take gap settings from the current data rate.
// RULE_10: Host should send the perpendicular command at initialisation, before drive access.
// RULE_11: Undefined command sets status bits 7 and 6, ends without interrupt.
// RULE_12: In DMA mode each transfer byte is requested by driving the DMA request.
// RULE_13: Host DMA cycles move bytes for the outstanding request.
// RULE_14: Writing one to rate register bit 6 enters low power and gates clocks.
// RULE_15: Software reset or data/status register access leaves low power.
// RULE_16: Waking by data/status access keeps all internal register values.
// RULE_17: Non-DMA flag from the timing setup command selects the transfer mode.
// RULE_18: Seek step pulses are spaced by the programmed step-rate interval.
// RULE_19: Codes between endpoints are linear: 0.5 ms per step code, 1 ms per head code.
package fdp_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_UNIT_NS = 500000;
    localparam int STEP_UNIT_CYC = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] OFF_DOR = 8'h00;
    localparam logic [7:0] OFF_MSR = 8'h04;
    localparam logic [7:0] OFF_DSR = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0c;
    localparam logic [7:0] OFF_CFG = 8'h10;
    localparam logic [7:0] OFF_TRK = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    localparam logic [7:0] OFF_MASK = 8'h1c;
    localparam int DOR_RSTN_BIT = 2;
    localparam int DSR_LP_BIT = 6;
    localparam int DSR_SWRST_BIT = 7;
    localparam logic [1:0] RATE_500K = 2'h0;
    localparam logic [1:0] RATE_300K = 2'h1;
    localparam logic [1:0] RATE_250K = 2'h2;
    localparam logic [1:0] RATE_1M = 2'h3;
    localparam logic [7:0] CMD_SPECIFY = 8'h03;
    localparam logic [7:0] CMD_WRITE = 8'h05;
    localparam logic [7:0] CMD_FORMAT = 8'h0d;
    localparam logic [7:0] CMD_SEEK = 8'h0f;
    localparam logic [7:0] CMD_PERP = 8'h12;
    localparam logic [7:0] INV_RESULT = 8'h80;
    localparam logic [7:0] MSR_INV = 8'hc0;
    localparam logic [8:0] SRT_SPAN = 9'h010;
    localparam logic [8:0] HLT_ZERO_UNITS = 9'h100;
    localparam logic [7:0] GAP_STD_LEN = 8'h16;
    localparam logic [7:0] GAP_1M_LEN = 8'h29;
    localparam logic [7:0] GAP_NO_RW = 8'h00;
    localparam logic [7:0] GAP_500_RW = 8'h13;
    localparam logic [7:0] GAP_1M_RW = 8'h26;
    localparam int IRQ_SEEK = 0;
    localparam int IRQ_XFER = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PARAM = 3'b001,
        ST_SEEK = 3'b010,
        ST_HLOAD = 3'b011,
        ST_XFER = 3'b100
    } fdp_st_t;
    typedef struct packed {
        logic [7:0] flen;
        logic [7:0] rlen;
    } fdp_gap_t;
endpackage

// ### logic/fdp_ctrl.sv
// Floppy controller core: command decode, seek, DMA transfer, perpendicular mode, low power.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
module fdp_ctrl #(
    parameter int STEP_UNIT_CYC = fdp_pkg::STEP_UNIT_CYC
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite register slave.
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq,
    // Drive side.
    output logic step_pulse,
    output logic step_dir,
    output logic head_load,
    output logic [1:0] drive_sel,
    output logic [3:0] drive_perp_mode,
    output fdp_pkg::fdp_gap_t post_id_gap_field,
    output logic [7:0] wr_byte,
    output logic wr_byte_valid,
    output logic clk_gate_en,
    // DMA side.
    output logic ldrq_n,
    input wire logic dma_cycle,
    input wire logic [7:0] dma_wdata
);
    // ****************************************************************
    // State and helpers.
    // ****************************************************************
    typedef struct packed {
        fdp_pkg::fdp_st_t st;
        logic [7:0] cmd;
        logic [1:0] pcnt;
        logic [7:0] p1;
        logic [3:0] step_rate_code;
        logic [6:0] head_load_code;
        logic nd;
        logic [3:0] dc;
        logic gap_length_select;
        logic wg;
        logic [3:0] perp;
        logic [1:0] rate;
        logic lp;
        logic cge;
        logic [1:0] drv;
        logic inv;
        logic [7:0] pcn;
        logic [7:0] ncn;
        logic [17:0] div;
        logic [8:0] ucnt;
        logic [8:0] bcnt;
        logic [1:0] ist;
        logic [1:0] imask;
        logic irq;
        logic step;
        logic dir;
        logic hl;
        logic ldrq_n;
        logic [7:0] wbyte;
        logic wbv;
        fdp_pkg::fdp_gap_t gapo;
        logic awg;
        logic [7:0] awa;
        logic wgot;
        logic [7:0] wd;
        logic wst;
        logic awrdy;
        logic wrdy;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } fdp_regs_t;

    fdp_regs_t s_reg;
    fdp_regs_t s_next;
    logic tick;
    logic do_wr;
    logic swrst;
    logic wake;
    logic lp_set;
    logic dbyte_ok;
    logic [7:0] dbyte;
    logic xbyte;
    logic [7:0] xdata;
    logic [8:0] srt_units;
    logic [8:0] hl_units;

    // Length of one step-rate unit in cycles minus one, scaled by data rate.
    function automatic logic [17:0] tick_len(input logic [1:0] r);
        case (r)
            fdp_pkg::RATE_1M: tick_len = 18'(STEP_UNIT_CYC - 1); // RULE_01
            fdp_pkg::RATE_500K: tick_len = 18'(2 * STEP_UNIT_CYC - 1); // RULE_01
            fdp_pkg::RATE_300K: tick_len = 18'((10 * STEP_UNIT_CYC) / 3 - 1); // RULE_01
            default: tick_len = 18'(4 * STEP_UNIT_CYC - 1); // RULE_01
        endcase
    endfunction

    // Gap field length and rewritten portion for the selected drive.
    function automatic fdp_pkg::fdp_gap_t gap_sel(input logic [3:0] dc, input logic [1:0] gw,
                                                  input logic [1:0] drv, input logic [1:0] rate);
        fdp_pkg::fdp_gap_t g;
        logic perp;
        logic fast;
        perp = dc[drv];
        fast = rate == fdp_pkg::RATE_1M;
        g.flen = fdp_pkg::GAP_STD_LEN;
        g.rlen = fdp_pkg::GAP_NO_RW;
        if (gw == 2'h3 || (gw == 2'h0 && perp && fast)) begin // RULE_07 RULE_08
            g.flen = fdp_pkg::GAP_1M_LEN;
            g.rlen = fdp_pkg::GAP_1M_RW;
        end else if (gw == 2'h1 || (gw == 2'h0 && perp)) begin // RULE_07 RULE_08
            g.rlen = fdp_pkg::GAP_500_RW;
        end
        return g;
    endfunction

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    always_comb begin
        s_next = s_reg;
        s_next.step = 1'b0;
        s_next.wbv = 1'b0;
        swrst = 1'b0;
        wake = 1'b0;
        lp_set = 1'b0;
        dbyte_ok = 1'b0;
        dbyte = 8'h00;
        xbyte = 1'b0;
        xdata = 8'h00;
        srt_units = fdp_pkg::SRT_SPAN - {5'h00, s_reg.step_rate_code}; // RULE_19
        hl_units = (s_reg.head_load_code == 7'h00) ? fdp_pkg::HLT_ZERO_UNITS : {1'b0, s_reg.head_load_code, 1'b0}; // RULE_02 RULE_19
        tick = !s_reg.lp && (s_reg.div >= tick_len(s_reg.rate));
        if (!s_reg.lp) begin // RULE_14
            s_next.div = tick ? 18'h0 : s_reg.div + 18'h1;
        end
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_reg.arrdy && arvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = fdp_pkg::RESP_OKAY;
            s_next.rdata = 8'h00;
            case (araddr)
                fdp_pkg::OFF_DOR: s_next.rdata = {5'h00, 1'b1, s_reg.drv};
                fdp_pkg::OFF_MSR: begin
                    wake = 1'b1; // RULE_15
                    if (s_reg.inv) begin
                        s_next.rdata = fdp_pkg::MSR_INV; // RULE_11
                    end else begin
                        s_next.rdata = {s_reg.st == fdp_pkg::ST_IDLE || s_reg.st == fdp_pkg::ST_PARAM ||
                                        (s_reg.st == fdp_pkg::ST_XFER && s_reg.nd), 1'b0,
                                        s_reg.st == fdp_pkg::ST_XFER && s_reg.nd,
                                        s_reg.st != fdp_pkg::ST_IDLE, 4'h0};
                    end
                end
                fdp_pkg::OFF_DSR: s_next.rdata = {1'b0, s_reg.lp, 4'h0, s_reg.rate};
                fdp_pkg::OFF_DATA: begin
                    wake = 1'b1; // RULE_15
                    s_next.rdata = s_reg.inv ? fdp_pkg::INV_RESULT : 8'h00;
                    s_next.inv = 1'b0;
                end
                fdp_pkg::OFF_CFG: s_next.rdata = {s_reg.dc, s_reg.nd, 1'b0, s_reg.gap_length_select, s_reg.wg};
                fdp_pkg::OFF_TRK: s_next.rdata = s_reg.pcn;
                fdp_pkg::OFF_STAT: s_next.rdata = {6'h00, s_reg.ist};
                fdp_pkg::OFF_MASK: s_next.rdata = {6'h00, s_reg.imask};
                default: s_next.rresp = fdp_pkg::RESP_SLVERR;
            endcase
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.awrdy && awvalid) begin
            s_next.awg = 1'b1;
            s_next.awa = awaddr;
        end
        if (s_reg.wrdy && wvalid) begin
            s_next.wgot = 1'b1;
            s_next.wd = wdata[7:0];
            s_next.wst = wstrb[0];
        end
        do_wr = s_next.awg && s_next.wgot && !s_reg.bvalid;
        if (do_wr) begin
            s_next.awg = 1'b0;
            s_next.wgot = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = fdp_pkg::RESP_OKAY;
            case (s_next.awa)
                fdp_pkg::OFF_DOR: begin
                    if (s_next.wst) begin
                        s_next.drv = s_next.wd[1:0];
                        swrst = !s_next.wd[fdp_pkg::DOR_RSTN_BIT]; // RULE_15
                    end
                end
                fdp_pkg::OFF_DSR: begin
                    if (s_next.wst) begin
                        s_next.rate = s_next.wd[1:0];
                        swrst = s_next.wd[fdp_pkg::DSR_SWRST_BIT]; // RULE_15
                        lp_set = s_next.wd[fdp_pkg::DSR_LP_BIT]; // RULE_14
                    end
                end
                fdp_pkg::OFF_MSR: wake = 1'b1; // RULE_15
                fdp_pkg::OFF_DATA: begin
                    wake = 1'b1; // RULE_15
                    dbyte_ok = s_next.wst;
                    dbyte = s_next.wd;
                end
                fdp_pkg::OFF_STAT: begin
                    if (s_next.wst) begin
                        s_next.ist = s_reg.ist & ~s_next.wd[1:0];
                    end
                end
                fdp_pkg::OFF_MASK: begin
                    if (s_next.wst) begin
                        s_next.imask = s_next.wd[1:0];
                    end
                end
                fdp_pkg::OFF_CFG, fdp_pkg::OFF_TRK: s_next.bresp = fdp_pkg::RESP_OKAY;
                default: s_next.bresp = fdp_pkg::RESP_SLVERR;
            endcase
        end
        case (s_reg.st)
            fdp_pkg::ST_IDLE: begin
                if (dbyte_ok) begin
                    s_next.cmd = dbyte;
                    case (dbyte)
                        fdp_pkg::CMD_SPECIFY, fdp_pkg::CMD_SEEK: begin
                            s_next.pcnt = 2'h2;
                            s_next.st = fdp_pkg::ST_PARAM;
                        end
                        fdp_pkg::CMD_PERP, fdp_pkg::CMD_WRITE, fdp_pkg::CMD_FORMAT: begin
                            s_next.pcnt = 2'h1;
                            s_next.st = fdp_pkg::ST_PARAM;
                        end
                        default: s_next.inv = 1'b1; // RULE_11
                    endcase
                end
            end
            fdp_pkg::ST_PARAM: begin
                if (dbyte_ok) begin
                    s_next.pcnt = s_reg.pcnt - 2'h1;
                    s_next.p1 = dbyte;
                    if (s_reg.pcnt == 2'h1) begin
                        s_next.st = fdp_pkg::ST_IDLE;
                        case (s_reg.cmd)
                            fdp_pkg::CMD_SPECIFY: begin
                                s_next.step_rate_code = s_reg.p1[7:4];
                                s_next.head_load_code = dbyte[7:1];
                                s_next.nd = dbyte[0]; // RULE_17
                            end
                            fdp_pkg::CMD_PERP: begin
                                s_next.dc = dbyte[5:2]; // RULE_03
                                s_next.gap_length_select = dbyte[1]; // RULE_03
                                s_next.wg = dbyte[0]; // RULE_03
                            end
                            fdp_pkg::CMD_SEEK: begin
                                s_next.ncn = dbyte;
                                s_next.ucnt = 9'h000;
                                s_next.st = fdp_pkg::ST_SEEK;
                            end
                            default: begin
                                s_next.bcnt = (dbyte == 8'h00) ? 9'h100 : {1'b0, dbyte};
                                s_next.gapo = gap_sel(s_reg.dc, {s_reg.gap_length_select, s_reg.wg}, s_reg.drv, s_reg.rate); // RULE_09
                                s_next.hl = 1'b1;
                                s_next.ucnt = 9'h000;
                                s_next.st = fdp_pkg::ST_HLOAD;
                            end
                        endcase
                    end
                end
            end
            fdp_pkg::ST_SEEK: begin
                if (tick) begin
                    if (s_reg.pcn == s_reg.ncn) begin
                        s_next.st = fdp_pkg::ST_IDLE;
                        s_next.ist[fdp_pkg::IRQ_SEEK] = 1'b1;
                    end else if (s_reg.ucnt == srt_units - 9'h001) begin // RULE_18
                        s_next.ucnt = 9'h000;
                        s_next.step = 1'b1;
                        s_next.dir = s_reg.ncn > s_reg.pcn;
                        s_next.pcn = (s_reg.ncn > s_reg.pcn) ? s_reg.pcn + 8'h01 : s_reg.pcn - 8'h01;
                    end else begin
                        s_next.ucnt = s_reg.ucnt + 9'h001;
                    end
                end
            end
            fdp_pkg::ST_HLOAD: begin
                if (tick) begin
                    if (s_reg.ucnt == hl_units - 9'h001) begin // RULE_02
                        s_next.st = fdp_pkg::ST_XFER;
                    end else begin
                        s_next.ucnt = s_reg.ucnt + 9'h001;
                    end
                end
            end
            fdp_pkg::ST_XFER: begin
                xbyte = s_reg.nd ? dbyte_ok : (dma_cycle && !s_reg.ldrq_n); // RULE_13 RULE_17
                xdata = s_reg.nd ? dbyte : dma_wdata;
                if (xbyte) begin
                    s_next.wbyte = xdata; // RULE_13
                    s_next.wbv = 1'b1;
                    s_next.ldrq_n = 1'b1;
                    s_next.bcnt = s_reg.bcnt - 9'h001;
                    if (s_reg.bcnt == 9'h001) begin
                        s_next.st = fdp_pkg::ST_IDLE;
                        s_next.hl = 1'b0;
                        s_next.ist[fdp_pkg::IRQ_XFER] = 1'b1;
                    end
                end else if (!s_reg.nd && !s_reg.lp) begin
                    s_next.ldrq_n = 1'b0; // RULE_12
                end
            end
            default: s_next.st = fdp_pkg::ST_IDLE;
        endcase
        if (swrst) begin
            s_next.gap_length_select = 1'b0; // RULE_06
            s_next.wg = 1'b0; // RULE_06
            s_next.st = fdp_pkg::ST_IDLE;
            s_next.inv = 1'b0;
            s_next.lp = 1'b0; // RULE_15
            s_next.ldrq_n = 1'b1;
            s_next.hl = 1'b0;
        end
        if (lp_set) begin
            s_next.lp = 1'b1; // RULE_14
        end
        if (wake) begin
            s_next.lp = 1'b0; // RULE_15 RULE_16
        end
        for (int i = 0; i < 4; i++) begin
            s_next.perp[i] = (s_next.gap_length_select || s_next.wg) ? s_next.wg : s_next.dc[i]; // RULE_04 RULE_05
        end
        s_next.cge = !s_next.lp; // RULE_14
        s_next.irq = |(s_next.ist & s_next.imask);
        s_next.awrdy = !s_next.awg && !s_next.bvalid;
        s_next.wrdy = !s_next.wgot && !s_next.bvalid;
        s_next.arrdy = !s_next.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.ldrq_n <= 1'b1;
            s_reg.cge <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign awready = s_reg.awrdy;
    assign wready = s_reg.wrdy;
    assign bresp = s_reg.bresp;
    assign bvalid = s_reg.bvalid;
    assign arready = s_reg.arrdy;
    assign rdata = {24'h000000, s_reg.rdata};
    assign rresp = s_reg.rresp;
    assign rvalid = s_reg.rvalid;
    assign irq = s_reg.irq;
    assign step_pulse = s_reg.step;
    assign step_dir = s_reg.dir;
    assign head_load = s_reg.hl;
    assign drive_sel = s_reg.drv;
    assign drive_perp_mode = s_reg.perp;
    assign post_id_gap_field = s_reg.gapo;
    assign wr_byte = s_reg.wbyte;
    assign wr_byte_valid = s_reg.wbv;
    assign clk_gate_en = s_reg.cge;
    assign ldrq_n = s_reg.ldrq_n;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    logic [31:0] since_step;
    logic seen_step;
    logic [31:0] min_gap;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            since_step <= 32'h0;
            seen_step <= 1'b0;
        end else begin
            since_step <= s_reg.step ? 32'h0 : since_step + 32'h1;
            seen_step <= (s_reg.st == fdp_pkg::ST_SEEK) && (seen_step || s_reg.step);
        end
    end

    assign min_gap = 32'(srt_units) * (32'(tick_len(s_reg.rate)) + 32'h1);

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence seq_lp_wr;
        lp_set && !wake;
    endsequence
    sequence seq_hload_start;
        (s_reg.st == fdp_pkg::ST_PARAM) ##1 (s_reg.st == fdp_pkg::ST_HLOAD);
    endsequence
    sequence seq_wake_rd;
        s_reg.arrdy && arvalid && !do_wr && (araddr == fdp_pkg::OFF_MSR || araddr == fdp_pkg::OFF_DATA);
    endsequence

    AST_LP_ENTER: assert property (seq_lp_wr |=> s_reg.lp && !clk_gate_en) // RULE_14
        else $error("low power not entered after rate register write");
    AST_SWRST_GAP: assert property (swrst |=> !s_reg.gap_length_select && !s_reg.wg && s_reg.dc == $past(s_reg.dc)) // RULE_06
        else $error("software reset handled gap bits wrongly");
    AST_INV_NO_IRQ: assert property ($rose(s_reg.inv) |-> s_reg.ist == $past(s_reg.ist) && !$rose(irq)) // RULE_11
        else $error("undefined command raised an interrupt");
    AST_PAIR_OVERRIDE: assert property ((s_reg.gap_length_select || s_reg.wg) |-> drive_perp_mode == {4{s_reg.wg}}) // RULE_04
        else $error("gap pair did not override drive bits");
    AST_DC_SELECT: assert property ((!s_reg.gap_length_select && !s_reg.wg) |-> drive_perp_mode == s_reg.dc) // RULE_05
        else $error("drive select bits not applied");
    AST_GAP_TABLE: assert property (seq_hload_start |-> (!(s_reg.gap_length_select && s_reg.wg) || // RULE_07
        (post_id_gap_field.flen == fdp_pkg::GAP_1M_LEN && post_id_gap_field.rlen == fdp_pkg::GAP_1M_RW)) &&
        (!(s_reg.gap_length_select && !s_reg.wg) || post_id_gap_field.rlen == fdp_pkg::GAP_NO_RW))
        else $error("gap length does not match gap pair");
    AST_STEP_SPACING: assert property ((s_reg.step && seen_step) |-> since_step + 32'h1 >= min_gap) // RULE_18
        else $error("step pulses too close together");
    AST_LDRQ_DMA: assert property (!ldrq_n |-> s_reg.st == fdp_pkg::ST_XFER && !s_reg.nd) // RULE_17
        else $error("DMA request outside a DMA transfer");
    AST_DMA_BYTE: assert property ((s_reg.st == fdp_pkg::ST_XFER && !ldrq_n && dma_cycle) |=> // RULE_13
        wr_byte_valid && wr_byte == $past(dma_wdata) && ldrq_n)
        else $error("DMA cycle did not move a byte");
    AST_WAKE: assert property (seq_wake_rd |=> !s_reg.lp && s_reg.step_rate_code == $past(s_reg.step_rate_code)) // RULE_16
        else $error("status or data read did not wake the block");
endmodule

// ### tb/fdp_dma_host.sv
// Host DMA agent model answering the controller request line.
module fdp_dma_host (
    // Clock.
    input wire logic aclk,
    // Request and cycle.
    input wire logic ldrq_n,
    output logic dma_cycle,
    output logic [7:0] dma_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        dma_cycle = 1'b0;
        dma_wdata = 8'h00;
    end
    // Answers a pending request after a random stall.
    always @(posedge aclk) begin
        dma_cycle <= !ldrq_n && !dma_cycle && ($urandom % 3 == 0);
        dma_wdata <= 8'($urandom);
    end
endmodule

// ### tb/fdp_ctrl_test.sv
// Self-checking bench for the floppy controller core.
module fdp_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int U = 4;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic irq, step_pulse, step_dir, head_load, wr_byte_valid, clk_gate_en, ldrq_n, dma_cycle, p, big;
    logic [7:0] awaddr, araddr, dma_wdata, wr_byte, d;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, drive_perp_mode, dc;
    logic [1:0] bresp, rresp, drive_sel, r;
    logic [15:0] e;
    fdp_pkg::fdp_gap_t post_id_gap_field;
    int fails = 0, n_tests = 0, cyc = 0, nb = 0, c, h, m, n, s;
    int st[$];
    logic [7:0] bq[$];
    fdp_ctrl #(.STEP_UNIT_CYC(U)) i_fdp_ctrl (.*);
    fdp_dma_host i_fdp_dma_host (.*);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (step_pulse) st.push_back(cyc);
        if (dma_cycle && !ldrq_n) bq.push_back(dma_wdata);
        if (wr_byte_valid) begin
            nb++;
            chk(wr_byte, bq.pop_front());
        end
        if (cyc == 60000) begin
            fails++;
            conclude();
        end
    end
    task automatic chk(input logic [23:0] g, input logic [23:0] x);
        n_tests++;
        if (g !== x) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, v};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        v = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        aresetn = 1'b0;
        wstrb = 4'hf;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        void'($urandom(32'hd5e7));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        wr(fdp_pkg::OFF_MASK, 8'h01);
        wr(fdp_pkg::OFF_DATA, 8'h00);
        rd(fdp_pkg::OFF_MSR, d);
        chk(d, fdp_pkg::MSR_INV);
        rd(fdp_pkg::OFF_DATA, d);
        chk({d, irq}, {fdp_pkg::INV_RESULT, 1'b0});
        c = 8 + $urandom % 8;
        h = 1 + $urandom % 3;
        wr(fdp_pkg::OFF_DATA, fdp_pkg::CMD_SPECIFY);
        wr(fdp_pkg::OFF_DATA, 8'(c << 4));
        wr(fdp_pkg::OFF_DATA, 8'(h << 1));
        wr(fdp_pkg::OFF_DATA, fdp_pkg::CMD_PERP);
        wr(fdp_pkg::OFF_DATA, 8'h00);
        for (int i = 0; i < 4; i++) begin
            m = (i == 0) ? U : (i == 3) ? 10 * U / 3 : 2 * i * U;
            wr(fdp_pkg::OFF_DSR, 8'(i == 0 ? 3 : i == 3 ? 1 : i * 2 - 2));
            st.delete();
            wr(fdp_pkg::OFF_DATA, fdp_pkg::CMD_SEEK);
            wr(fdp_pkg::OFF_DATA, 8'h00);
            wr(fdp_pkg::OFF_DATA, i[0] ? 8'h00 : 8'h03);
            do rd(fdp_pkg::OFF_STAT, d); while (!d[0]);
            chk({irq, step_dir, 6'(st.size())}, {1'b1, !i[0], 6'd3});
            chk(st[2] - st[1], (16 - c) * m);
            rd(fdp_pkg::OFF_TRK, d);
            chk(d, i[0] ? 8'h00 : 8'h03);
            wr(fdp_pkg::OFF_STAT, 8'h01);
        end
        for (int i = 0; i < 8; i++) begin
            dc = 4'($urandom);
            s = $urandom % 4;
            m = i[2] ? 1 : 2;
            wr(fdp_pkg::OFF_DOR, 8'(4 + s));
            wr(fdp_pkg::OFF_DSR, i[2] ? 8'h03 : 8'h00);
            wr(fdp_pkg::OFF_DATA, fdp_pkg::CMD_PERP);
            wr(fdp_pkg::OFF_DATA, {2'b0, dc, i[1:0]});
            chk({drive_sel, drive_perp_mode}, {2'(s), i[1:0] != 0 ? {4{i[0]}} : dc});
            p = (i[1:0] == 0) ? dc[s] : i[0];
            big = (i[1:0] == 3) || (i[1:0] == 0 && i[2]);
            e = !p ? 16'h1600 : big ? 16'h2926 : 16'h1613;
            nb = 0;
            wr(fdp_pkg::OFF_DATA, $urandom % 2 ? fdp_pkg::CMD_FORMAT : fdp_pkg::CMD_WRITE);
            wr(fdp_pkg::OFF_DATA, 8'h03);
            for (n = 0; ldrq_n; n++) @(posedge aclk);
            chk({n <= 2 * h * U * m + 1 && n >= (2 * h - 1) * U * m + 2, head_load}, 2'b11);
            do rd(fdp_pkg::OFF_STAT, d); while (!d[1]);
            chk({post_id_gap_field, 7'(nb), irq}, {e, 8'h06});
            wr(fdp_pkg::OFF_MASK, 8'h02);
            rd(fdp_pkg::OFF_MASK, d);
            chk({d, irq}, 9'h005);
            wr(fdp_pkg::OFF_STAT, 8'h02);
            rd(fdp_pkg::OFF_STAT, d);
            chk({d, irq}, 9'h000);
            wr(fdp_pkg::OFF_MASK, 8'h01);
        end
        wr(fdp_pkg::OFF_DATA, fdp_pkg::CMD_SPECIFY);
        wr(fdp_pkg::OFF_DATA, 8'(c << 4));
        wr(fdp_pkg::OFF_DATA, 8'(h << 1) + 8'h01);
        nb = 0;
        wr(fdp_pkg::OFF_DATA, fdp_pkg::CMD_WRITE);
        wr(fdp_pkg::OFF_DATA, 8'h02);
        repeat (2) begin
            do rd(fdp_pkg::OFF_MSR, d); while (!d[7]);
            chk(d[5], 1'b1);
            d = 8'($urandom);
            bq.push_back(d);
            wr(fdp_pkg::OFF_DATA, d);
        end
        do rd(fdp_pkg::OFF_STAT, d); while (!d[1]);
        chk({7'(nb), ldrq_n, head_load}, 9'h00a);
        wr(fdp_pkg::OFF_DOR, 8'h00);
        wr(fdp_pkg::OFF_DOR, 8'h04);
        rd(fdp_pkg::OFF_CFG, d);
        chk({d[7:4], d[1:0], drive_perp_mode}, {dc, 2'b00, dc});
        wr(fdp_pkg::OFF_DSR, 8'h43);
        rd(fdp_pkg::OFF_DSR, d);
        chk({d, clk_gate_en}, 9'h086);
        rd(fdp_pkg::OFF_MSR, d);
        rd(fdp_pkg::OFF_CFG, d);
        chk({d, clk_gate_en}, {dc, 5'h11});
        wr(fdp_pkg::OFF_DSR, 8'h40);
        wr(fdp_pkg::OFF_DSR, 8'h80);
        rd(fdp_pkg::OFF_DSR, d);
        chk({d[6], clk_gate_en}, 2'b01);
        wr(8'h20, 8'h00);
        chk(r, fdp_pkg::RESP_SLVERR);
        rd(8'h20, d);
        chk({r, d}, {fdp_pkg::RESP_SLVERR, 8'h00});
        conclude();
    end
endmodule
